/* src/half_width_target_adapter.sv */
// half-width target adapter: splits 32-bit bus cycles for a 16-bit core
// assumes bus pins already resolved; enables are active high, logical
`timescale 1ns/1ps
// Rules for host, master, board and this block
// RULE1 - host encodes lane enables from byte signals
// RULE2 - assert half-width ack for 16-bit target
// RULE3 - first transfer uses low word, forces second
// RULE4 - owner repeats upper lanes, negates low lanes
// RULE5 - single-word cycles need no second transfer
// RULE6 - take upper write data from lanes 3,2
// RULE7 - never rely on write data duplication
// RULE8 - second read drives both data words
// RULE9 - reads drive all 32 data lines
// RULE10 - master keeps true lanes on second transfer
// RULE11 - lane 3 and 2 buffer enables
// RULE12 - lane 1 and 0 buffer enables
// RULE13 - decode byte signals from lane enables
// RULE14 - burst steps split, second two higher
// RULE15 - split burst order set by start address
// RULE16 - board gives 16 stable clocks in reset
// RULE17 - float data and ready lines in reset
// RULE18 - target never drives master-only lines in reset
// RULE19 - claim low only from valid address decode
// RULE20 - target never drives master-owned signals
// RULE21 - board drives clock, reset, capability bits
// RULE22 - hold read data until ready return
module half_width_target_adapter
  import hw_adapt_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic CE,
  input wire logic CYCLE_START,
  input wire logic WRITE_CYCLE,
  input wire logic [3:0] LANE_EN_IN,
  input wire logic [3:0] START_ADDR,
  input wire logic ADDR_HIT,
  input wire logic [31:0] DATA_IN,
  input wire logic XFER_DONE,
  input wire logic READY_RETURN_IN,
  input wire logic [15:0] CORE_RDATA,
  output logic HALF_ACK_OUT,
  output logic HALF_ACK_OE_N,
  output logic CLAIM_OUT,
  output logic CLAIM_OE_N,
  output logic [31:0] DATA_OUT,
  output logic DATA_OE_N,
  output logic [3:0] BUF_EN,
  output logic [15:0] CORE_WDATA,
  output logic CORE_WE,
  output logic CORE_LOW_BYTE,
  output logic CORE_HIGH_BYTE,
  output logic CORE_WORD_ADDR,
  output logic [3:0] BURST_ADDR
);
  xfer_state_t state_reg;
  logic [3:0] lanes_reg;
  logic write_reg;
  logic [2:0] step_reg;
  logic [3:0] start_reg;
  logic rst_q1_reg;
  logic rst_q2_reg;

  function automatic logic [2:0] byte_decode(input logic [3:0] en);
    // low byte, high byte, word address bit
    byte_decode = {en[0] | (~en[1] & en[2]) | (~en[1] & en[3]),
                   en[1] | en[3], en[0] | en[1]};
  endfunction

  function automatic logic [3:0] burst_addr(input logic [3:0] st,
                                            input logic [2:0] k);
    logic [3:0] dw;
    dw = {k[2:1], 2'b00} ^ {st[3:2], 2'b00};
    burst_addr = dw + (k[0] ? HALF_STEP : LANES_NONE);
  endfunction

  // reset edge tracking for the release cycle
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      rst_q1_reg <= 1'b0;
      rst_q2_reg <= 1'b0;
    end
    else if (CE)
    begin
      rst_q1_reg <= 1'b1;
      rst_q2_reg <= rst_q1_reg;
    end
  end

  // RULE3 RULE5 split sequencing
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      state_reg <= ST_IDLE;
      lanes_reg <= LANES_NONE;
      write_reg <= 1'b0;
    end
    else if (CE)
    begin
      unique case (state_reg)
        ST_IDLE:
        begin
          if (CYCLE_START && ADDR_HIT)
          begin
            state_reg <= ST_FIRST;
            lanes_reg <= LANE_EN_IN;
            write_reg <= WRITE_CYCLE;
          end
        end
        ST_FIRST:
        begin
          if (XFER_DONE)
          begin
            if (!write_reg)
              state_reg <= ST_HOLD;
            else
              state_reg <= ST_IDLE;
          end
          else if (CYCLE_START)
          begin
            state_reg <= ST_SECOND;
            lanes_reg <= LANE_EN_IN;
          end
        end
        ST_SECOND:
        begin
          if (XFER_DONE)
            state_reg <= write_reg ? ST_IDLE : ST_HOLD;
        end
        ST_HOLD:
        begin
          // RULE22 hold until return
          if (READY_RETURN_IN)
            state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // RULE14 RULE15 burst address order
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      step_reg <= 3'h0;
      start_reg <= RESET_ADDR;
      BURST_ADDR <= RESET_ADDR;
    end
    else if (CE)
    begin
      if (CYCLE_START && ADDR_HIT && state_reg == ST_IDLE)
      begin
        step_reg <= 3'h0;
        start_reg <= START_ADDR;
        BURST_ADDR <= START_ADDR;
      end
      else if (XFER_DONE &&
               (state_reg == ST_FIRST || state_reg == ST_SECOND))
      begin
        step_reg <= step_reg + 3'h1;
        BURST_ADDR <= burst_addr(start_reg, step_reg + 3'h1);
      end
    end
  end

  // RULE17 RULE18 RULE19 RULE20 pin drive control
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      HALF_ACK_OUT <= 1'b0;
      HALF_ACK_OE_N <= 1'b1;
      CLAIM_OUT <= 1'b0;
      CLAIM_OE_N <= 1'b1;
      DATA_OE_N <= 1'b1;
    end
    else if (CE)
    begin
      // RULE2 half-width ack
      HALF_ACK_OUT <= (state_reg == ST_FIRST || CYCLE_START) && ADDR_HIT;
      HALF_ACK_OE_N <= ~(state_reg != ST_IDLE || (CYCLE_START && ADDR_HIT));
      CLAIM_OUT <= ADDR_HIT && rst_q2_reg;
      CLAIM_OE_N <= ~(ADDR_HIT && rst_q2_reg);
      // RULE9 drive all lines on read
      DATA_OE_N <= ~((state_reg != ST_IDLE) && !write_reg);
    end
  end

  // RULE8 RULE9 read data on both words
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
      DATA_OUT <= {RESET_HALF_DATA, RESET_HALF_DATA};
    else if (CE && state_reg != ST_HOLD)
      DATA_OUT <= {CORE_RDATA, CORE_RDATA};
  end

  // RULE6 RULE7 write steering from true lanes
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      CORE_WDATA <= RESET_HALF_DATA;
      CORE_WE <= 1'b0;
    end
    else if (CE)
    begin
      CORE_WE <= XFER_DONE && write_reg &&
                 (state_reg == ST_FIRST || state_reg == ST_SECOND);
      if (|(lanes_reg & LO_WORD_MASK) && state_reg == ST_FIRST)
        CORE_WDATA <= DATA_IN[15:0];
      else
        CORE_WDATA <= DATA_IN[31:16];
    end
  end

  // RULE11 RULE12 RULE13 buffers and byte decode
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      BUF_EN <= LANES_NONE;
      {CORE_LOW_BYTE, CORE_HIGH_BYTE, CORE_WORD_ADDR} <= 3'h0;
    end
    else if (CE)
    begin
      BUF_EN[3] <= !write_reg || (lanes_reg[3] && !lanes_reg[1]);
      BUF_EN[2] <= !write_reg || (lanes_reg[2] && !lanes_reg[0]);
      BUF_EN[1] <= !write_reg || lanes_reg[1];
      BUF_EN[0] <= !write_reg || lanes_reg[0];
      {CORE_LOW_BYTE, CORE_HIGH_BYTE, CORE_WORD_ADDR} <=
        byte_decode(lanes_reg);
    end
  end

  // RULE17
  a_reset_float: assert property (@(posedge CLK) // RULE17
    !RST_N |=> DATA_OE_N && HALF_ACK_OE_N)
    else $error("pins driven during reset");
  a_read_hold: assert property (@(posedge CLK) disable iff (!RST_N) // RULE22
    CE && state_reg == ST_HOLD && !READY_RETURN_IN |=> state_reg == ST_HOLD)
    else $error("read hold dropped early");
  a_claim_decode: assert property (@(posedge CLK) disable iff (!RST_N) // RULE19
    !CLAIM_OE_N |-> $past(ADDR_HIT))
    else $error("claim without decode");
  a_data_dup: assert property (@(posedge CLK) disable iff (!RST_N) // RULE8
    DATA_OUT[31:16] == DATA_OUT[15:0])
    else $error("read words differ");
  a_buf_read: assert property (@(posedge CLK) disable iff (!RST_N) // RULE11
    CE && !write_reg |=> BUF_EN == 4'hF)
    else $error("read buffers off");
  a_buf_low: assert property (@(posedge CLK) disable iff (!RST_N) // RULE12
    CE && write_reg |=> BUF_EN[0] == $past(lanes_reg[0]))
    else $error("lane 0 buffer wrong");
  a_decode_hi: assert property (@(posedge CLK) disable iff (!RST_N) // RULE13
    CE |=> CORE_HIGH_BYTE == $past(lanes_reg[1] | lanes_reg[3]))
    else $error("high byte decode wrong");
  a_ack_first: assert property (@(posedge CLK) disable iff (!RST_N) // RULE3
    CE && state_reg == ST_FIRST && ADDR_HIT |=> HALF_ACK_OUT)
    else $error("no half ack on first");
  c_split_write: cover property (@(posedge CLK)
    state_reg == ST_FIRST ##1 state_reg == ST_SECOND);
  c_read_hold: cover property (@(posedge CLK) state_reg == ST_HOLD);
  c_burst_step: cover property (@(posedge CLK) step_reg == 3'h1);
endmodule

/* common/hw_adapt_pkg.sv */
// constants for the half-width target adapter
// assumes a single 100 MHz local clock
package hw_adapt_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int DATA_W = 32;
  localparam int HALF_W = 16;
  localparam int LANES = 4;
  localparam int BURST_STEPS = 8;
  localparam logic [3:0] LANES_NONE = 4'h0;
  localparam logic [3:0] LO_WORD_MASK = 4'h3;
  localparam logic [3:0] HI_WORD_MASK = 4'hC;
  localparam logic [3:0] HALF_STEP = 4'h2;
  localparam logic [15:0] RESET_HALF_DATA = 16'h0000;
  localparam logic [3:0] RESET_ADDR = 4'h0;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_FIRST = 2'b01,
    ST_SECOND = 2'b10,
    ST_HOLD = 2'b11
  } xfer_state_t;
endpackage

/* test/lane_host_model.sv */
// host side model: lane encoding and a late ready return
// assumes the bench pulses rd_done when a read transfer ends
`timescale 1ns/1ps
module lane_host_model (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic low_byte_enable,
  input wire logic high_byte_enable,
  input wire logic word_address_bit,
  input wire logic rd_done,
  output logic [3:0] lanes,
  output logic rdy_ret
);
  logic [1:0] cnt;
  assign lanes = {high_byte_enable & word_address_bit,
                  low_byte_enable & word_address_bit,
                  high_byte_enable & ~word_address_bit,
                  low_byte_enable & ~word_address_bit};
  always_ff @(posedge CLK)
  begin
    if (!RST_N)
    begin
      cnt <= 2'h0;
      rdy_ret <= 1'h0;
    end
    else
    begin
      cnt <= rd_done ? 2'h3 : (cnt != 2'h0 ? cnt - 2'h1 : cnt);
      rdy_ret <= (cnt == 2'h1);
    end
  end
endmodule

/* test/tb_half_width_target_adapter.sv */
// bench for the half-width target adapter
// assumes the host model answers reads late
`timescale 1ns/1ps
module tb_half_width_target_adapter;
  import hw_adapt_pkg::*;
  // row: {wr,lo_byte,hi_byte,word_bit} start, buffer enables, {low,high,word}
  logic [15:0] rows [5] = '{16'h60F7, 16'hE437, 16'hD844, 16'hBC86,
    16'h20F3};
  logic clk, rst_n, cs, wr, hit, done, lo_byte, hi_byte, word_bit, ovr;
  logic rr, hack, we, hoe, coe, oe_n, claim;
  logic [3:0] sa, lanes, ovl, h_lanes, buf_en, baddr;
  logic [31:0] din, dout;
  logic [15:0] wdata, r;
  logic [2:0] dec;
  int n_mismatch = 0, n_tests = 0, cyc = 0;
  half_width_target_adapter dut (.CLK(clk), .RST_N(rst_n), .CE(1'h1),
    .CYCLE_START(cs), .WRITE_CYCLE(wr), .LANE_EN_IN(lanes), .START_ADDR(sa),
    .ADDR_HIT(hit), .DATA_IN(din), .XFER_DONE(done), .READY_RETURN_IN(rr),
    .CORE_RDATA(16'h5AC3), .HALF_ACK_OUT(hack), .HALF_ACK_OE_N(hoe),
    .CLAIM_OUT(claim), .CLAIM_OE_N(coe), .DATA_OUT(dout), .DATA_OE_N(oe_n),
    .BUF_EN(buf_en), .CORE_WDATA(wdata), .CORE_WE(we),
    .CORE_LOW_BYTE(dec[2]), .CORE_HIGH_BYTE(dec[1]),
    .CORE_WORD_ADDR(dec[0]), .BURST_ADDR(baddr));
  lane_host_model host (.CLK(clk), .RST_N(rst_n),
    .low_byte_enable(lo_byte), .high_byte_enable(hi_byte),
    .word_address_bit(word_bit), .rd_done(done & ~wr), .lanes(h_lanes),
    .rdy_ret(rr));
  assign lanes = ovr ? ovl : h_lanes;
  task automatic print_verdict();
    if (n_mismatch == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic go();
    @(posedge clk);
    cs <= 1'h1;
    @(posedge clk);
    cs <= 1'h0;
    @(posedge clk) #1;
  endtask
  task automatic end_xfer(input logic [15:0] e);
    @(posedge clk);
    done <= 1'h1;
    @(posedge clk);
    done <= 1'h0;
    #1;
    if (wr)
    begin
      for (int i = 0; i < 3 && we !== 1'h1; i++) @(posedge clk) #1;
      chk("we", 1, we);
      chk("wdata", e, wdata);
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        chk("oe", 0, oe_n);
        chk("rdata", {e, e}, dout);
        @(posedge clk) #1;
      end
      for (int i = 0; i < 8 && oe_n !== 1'h1; i++) @(posedge clk) #1;
      chk("release", 1, oe_n);
    end
  endtask
  initial
  begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      n_mismatch++;
      print_verdict();
    end
  end
  initial
  begin
    {rst_n, cs, wr, done, lo_byte, hi_byte, word_bit, ovr} = 8'h0;
    hit = 1'h1;
    sa = 4'h0;
    ovl = 4'h0;
    din = 32'hA5A5_3C3C;
    repeat (2) @(posedge clk);
    #1;
    chk("oe", 3'h7, {hoe, coe, oe_n});
    chk("buf", 4'h0, buf_en);
    repeat (14) @(posedge clk);
    rst_n <= 1'h1;
    foreach (rows[k])
    begin
      r = rows[k];
      @(posedge clk);
      {wr, lo_byte, hi_byte, word_bit} <= r[15:12];
      sa <= r[11:8];
      go();
      chk("hack", 1, hack);
      chk("buf", r[7:4], buf_en);
      chk("dec", r[2:0], dec);
      chk("baddr", r[11:8], baddr);
      end_xfer(!wr ? 16'h5AC3 : (lanes & LO_WORD_MASK) != 4'h0 ?
        din[15:0] : din[31:16]);
    end
    @(posedge clk);
    {ovr, wr, ovl} <= {2'h3, 4'hF};
    go();
    chk("hack", 1, hack);
    end_xfer(din[15:0]);
    @(posedge clk);
    ovl <= 4'hC;
    din <= 32'h1234_DEAD;
    go();
    end_xfer(16'h1234);
    @(posedge clk);
    ovl <= 4'hF;
    go();
    @(posedge clk);
    ovl <= 4'hC;
    din <= 32'h5678_BEEF;
    go();
    end_xfer(16'h5678);
    chk("baddr", sa + HALF_STEP, baddr);
    @(posedge clk);
    {ovr, wr, hit} <= 3'h0;
    go();
    chk("hack", 0, hack);
    chk("hoe", 1, hoe);
    chk("coe", 1, coe);
    @(posedge clk);
    hit <= 1'h1;
    go();
    chk("oe", 3'h0, {hoe, coe, oe_n});
    chk("claim", 1, claim);
    @(posedge clk);
    rst_n <= 1'h0;
    @(posedge clk) #1;
    chk("oe", 3'h7, {hoe, coe, oe_n});
    print_verdict();
  end
endmodule
